// >>> core/viu_defines.svh
// Constants of the vectored priority interrupt unit
//
// Behaviour
// - Level n fetches its two-word vector, workspace then entry point, at byte 4n.
// - Level 0 is the highest priority, level 15 the lowest.
// - Interrupt mask is bits 12 to 15 of the status word.
// - Mask m enables levels 0 to m; level 0 is never disabled.
// - Best pending level at or below the mask is taken after the instruction.
// - Taking loads the vector's workspace pointer and entry point.
// - Old workspace, counter and status go to new registers 13, 14, 15.
// - No interrupt is taken until the handler's first instruction ends.
// - Mask becomes taken level minus one, never below zero.
// - A still active original request stays masked after a nested return.
// - Return restores workspace, counter and status from registers 13, 14, 15.
// - Level 0 is the power-on interrupt, vector at address zero.
// - Implemented level count is a build option of 8 or 16.
// - Several request lines may share a level, ORed together.
// - CPU errors request level 2; small build: parity and protect faults.
// - Set or clear of bit 12 at base 1fe0 clears the parity error.
// - Sense at 1fa0 shows 0 parity, 1 protect; writing one clears protect. Here the sense register holds only protect, at bit 0.
// - Large build shows five error causes at 1fc0, each cleared by its bit.
// - Set or clear of bit 4 at base 1fa0 clears the mapping error.
// - Extended operation traps use 16 vectors at 0040 to 007e, same switch.
// - Error bits: 12 bus memory, 13 illegal, 14 privileged fetch, 15 timeout.
// - Extended operation trap puts effective address in new register 11.
`ifndef VIU_DEFINES_SVH
`define VIU_DEFINES_SVH
`define VIU_MASK_LSB 12
`define VIU_MASK_MSB 15
`define VIU_ST_RESET 16'h0000
`define VIU_IRQ_VEC_BASE 16'h0000
`define VIU_XOP_VEC_BASE 16'h0040
`define VIU_ERR_LEVEL 2
`define VIU_WR_EA 11
`define VIU_WR_OLD_WP 13
`define VIU_WR_OLD_PC 14
`define VIU_WR_OLD_ST 15
`define VIU_IO_PANEL 16'h1fe0
`define VIU_IO_PROT 16'h1fa0
`define VIU_IO_ERR 16'h1fc0
`define VIU_BIT_PARITY 12
`define VIU_BIT_MAP 4
`define VIU_EB_MAP 11
`define VIU_EB_BUSMEM 12
`define VIU_EB_ILLEGAL 13
`define VIU_EB_PRIV 14
`define VIU_EB_TIMEOUT 15
`define VIU_REG_STATUS 3'h0
`define VIU_REG_WP 3'h1
`define VIU_REG_PC 3'h2
`define VIU_REG_PEND 3'h3
`define VIU_REG_ERR 3'h4
`define VIU_REG_SENSE 3'h5
`endif

// >>> core/viu_pkg.sv
// Types of the vectored priority interrupt unit
package viu_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_VEC_WP, S_VEC_PC, S_SAVE_WP, S_SAVE_PC, S_SAVE_ST, S_SAVE_EA,
      S_RET_WP, S_RET_PC, S_RET_ST
   } sw_state_type;
   typedef enum logic [1:0] {K_IRQ, K_XOP, K_RET} sw_kind_type;
endpackage : viu_pkg

// >>> core/vectored_priority_interrupt_unit.sv
// Interrupt priority, context switch engine, error sources and register slave
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "viu_defines.svh"
module vectored_priority_interrupt_unit #(
   parameter int LEVELS = 16,
   parameter int SHARE = 2,
   parameter bit PROT_FITTED = 1'b1
) (
   // Clock, reset, enable
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Request lines, SHARE per level
   input wire logic [16*SHARE-1:0] irq_lines_in,
   // Error sources, one-cycle pulses
   input wire logic err_parity_in,
   input wire logic err_protect_in,
   input wire logic err_map_in,
   input wire logic err_busmem_in,
   input wire logic err_illegal_in,
   input wire logic err_priv_in,
   input wire logic err_timeout_in,
   // CPU core side
   input wire logic instr_done_in,
   input wire logic [15:0] cpu_wp_in,
   input wire logic [15:0] cpu_pc_in,
   input wire logic st_we_in,
   input wire logic [15:0] st_wdata_in,
   input wire logic return_restore_context_in,
   input wire logic extended_op_trap_in,
   input wire logic [3:0] xop_num_in,
   input wire logic [15:0] xop_ea_in,
   input wire logic set_io_bit_one_in,
   input wire logic set_io_bit_zero_in,
   input wire logic [15:0] io_base_in,
   input wire logic [3:0] io_bit_in,
   output logic busy_out,
   output logic ctx_load_out,
   output logic [15:0] ctx_wp_out,
   output logic [15:0] ctx_pc_out,
   output logic [15:0] status_word_out,
   // Memory master
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [15:0] mem_addr_out,
   output logic [15:0] mem_wdata_out,
   input wire logic [15:0] mem_rdata_in,
   input wire logic mem_ack_in,
   // Avalon-MM slave
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);
   // Only 8 or 16 levels are served
   generate
      if (LEVELS != 8 && LEVELS != 16) begin : g_bad_levels
         $error("LEVELS must be 8 or 16");
      end
      if (SHARE < 1) begin : g_bad_share
         $error("SHARE must be at least 1");
      end
   endgenerate

   viu_pkg::sw_state_type state_ff, nxt_state;
   viu_pkg::sw_kind_type kind_ff, nxt_kind;
   logic [15:0] st_ff, nxt_st;
   logic [15:0] old_wp_ff, nxt_old_wp;
   logic [15:0] old_pc_ff, nxt_old_pc;
   logic [15:0] new_wp_ff, nxt_new_wp;
   logic [15:0] new_pc_ff, nxt_new_pc;
   logic [15:0] vaddr_ff, nxt_vaddr;
   logic [15:0] ea_ff, nxt_ea;
   logic [3:0] lvl_ff, nxt_lvl;
   logic inhibit_ff, nxt_inhibit;
   logic por_ff, nxt_por;
   logic load_ff, nxt_load;
   logic [15:0] maddr_ff, nxt_maddr;
   logic [15:0] mwdata_ff, nxt_mwdata;
   logic parity_ff, nxt_parity;
   logic protect_ff, nxt_protect;
   logic [15:0] errreg_ff, nxt_errreg;
   logic [15:0] level_req;
   logic [3:0] best_lvl;
   logic best_valid;
   logic take_go;
   logic last_ack;

   // Each level is the OR of its shared lines, with power-on added at level 0 and the error flags at level 2; absent levels read as idle
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_level
         logic lines_any;
         assign lines_any = |irq_lines_in[g*SHARE +: SHARE];
         if (g >= LEVELS) begin : g_absent
            assign level_req[g] = 1'b0;
         end else if (g == 0) begin : g_por
            assign level_req[g] = lines_any | por_ff;
         end else if (g == `VIU_ERR_LEVEL) begin : g_err
            assign level_req[g] = lines_any | parity_ff | protect_ff | (|errreg_ff);
         end else begin : g_plain
            assign level_req[g] = lines_any;
         end
      end
   endgenerate

   // Lowest number wins: scanning down, the last hit is the best
   always_comb begin
      best_lvl = 4'h0;
      best_valid = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (level_req[i]) begin
            best_lvl = 4'(i);
            best_valid = 1'b1;
         end
      end
   end

   // Take at an instruction boundary, or at once for power-on
   assign take_go = (state_ff == viu_pkg::S_IDLE) && best_valid && !inhibit_ff
      && (best_lvl <= st_ff[`VIU_MASK_MSB:`VIU_MASK_LSB])
      && (instr_done_in || por_ff);

   assign last_ack = mem_ack_in && (state_ff == viu_pkg::S_RET_ST
      || state_ff == viu_pkg::S_SAVE_EA
      || (state_ff == viu_pkg::S_SAVE_ST && kind_ff != viu_pkg::K_XOP));

   // Memory address and data per state
   function automatic logic [31:0] mem_for(input viu_pkg::sw_state_type s,
         input logic [15:0] va, input logic [15:0] nwp, input logic [15:0] owp,
         input logic [15:0] opc, input logic [15:0] ost, input logic [15:0] ea);
      logic [15:0] a;
      logic [15:0] d;
      a = 16'h0000;
      d = 16'h0000;
      case (s)
         viu_pkg::S_VEC_WP: a = va;
         viu_pkg::S_VEC_PC: a = va + 16'h0002;
         viu_pkg::S_SAVE_WP: begin
            a = nwp + 16'(2 * `VIU_WR_OLD_WP);
            d = owp;
         end
         viu_pkg::S_SAVE_PC: begin
            a = nwp + 16'(2 * `VIU_WR_OLD_PC);
            d = opc;
         end
         viu_pkg::S_SAVE_ST: begin
            a = nwp + 16'(2 * `VIU_WR_OLD_ST);
            d = ost;
         end
         viu_pkg::S_SAVE_EA: begin
            a = nwp + 16'(2 * `VIU_WR_EA);
            d = ea;
         end
         viu_pkg::S_RET_WP: a = owp + 16'(2 * `VIU_WR_OLD_WP);
         viu_pkg::S_RET_PC: a = owp + 16'(2 * `VIU_WR_OLD_PC);
         viu_pkg::S_RET_ST: a = owp + 16'(2 * `VIU_WR_OLD_ST);
         default: a = 16'h0000;
      endcase
      return {a, d};
   endfunction : mem_for

   // Context switch sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_kind = kind_ff;
      nxt_st = st_ff;
      nxt_old_wp = old_wp_ff;
      nxt_old_pc = old_pc_ff;
      nxt_new_wp = new_wp_ff;
      nxt_new_pc = new_pc_ff;
      nxt_vaddr = vaddr_ff;
      nxt_ea = ea_ff;
      nxt_lvl = lvl_ff;
      nxt_inhibit = inhibit_ff;
      nxt_por = por_ff;
      nxt_load = 1'b0;
      // Status writes from the core take priority over the bus
      if (st_we_in) begin
         nxt_st = st_wdata_in;
      end else if (avs_write_in && !avs_waitrequest_out
            && avs_address_in[4:2] == `VIU_REG_STATUS) begin
         nxt_st = avs_writedata_in[15:0];
      end
      // First handler instruction done lifts the hold-off
      if (instr_done_in && state_ff == viu_pkg::S_IDLE) begin
         nxt_inhibit = 1'b0;
      end
      case (state_ff)
         viu_pkg::S_IDLE: begin
            nxt_old_wp = cpu_wp_in;
            nxt_old_pc = cpu_pc_in;
            if (take_go) begin
               nxt_kind = viu_pkg::K_IRQ;
               nxt_lvl = best_lvl;
               nxt_vaddr = `VIU_IRQ_VEC_BASE + {10'h000, best_lvl, 2'b00};
               if (best_lvl == 4'h0) begin
                  nxt_por = 1'b0;
               end
               nxt_state = viu_pkg::S_VEC_WP;
            end else if (extended_op_trap_in) begin
               nxt_kind = viu_pkg::K_XOP;
               nxt_ea = xop_ea_in;
               nxt_vaddr = `VIU_XOP_VEC_BASE + {10'h000, xop_num_in, 2'b00};
               nxt_state = viu_pkg::S_VEC_WP;
            end else if (return_restore_context_in) begin
               nxt_kind = viu_pkg::K_RET;
               nxt_state = viu_pkg::S_RET_WP;
            end
         end
         viu_pkg::S_VEC_WP: if (mem_ack_in) begin
            nxt_new_wp = mem_rdata_in;
            nxt_state = viu_pkg::S_VEC_PC;
         end
         viu_pkg::S_VEC_PC: if (mem_ack_in) begin
            nxt_new_pc = mem_rdata_in;
            nxt_state = viu_pkg::S_SAVE_WP;
         end
         viu_pkg::S_SAVE_WP: if (mem_ack_in) nxt_state = viu_pkg::S_SAVE_PC;
         viu_pkg::S_SAVE_PC: if (mem_ack_in) nxt_state = viu_pkg::S_SAVE_ST;
         viu_pkg::S_SAVE_ST: if (mem_ack_in) begin
            nxt_state = (kind_ff == viu_pkg::K_XOP) ? viu_pkg::S_SAVE_EA : viu_pkg::S_IDLE;
         end
         viu_pkg::S_SAVE_EA: if (mem_ack_in) nxt_state = viu_pkg::S_IDLE;
         viu_pkg::S_RET_WP: if (mem_ack_in) begin
            nxt_new_wp = mem_rdata_in;
            nxt_state = viu_pkg::S_RET_PC;
         end
         viu_pkg::S_RET_PC: if (mem_ack_in) begin
            nxt_new_pc = mem_rdata_in;
            nxt_state = viu_pkg::S_RET_ST;
         end
         viu_pkg::S_RET_ST: if (mem_ack_in) begin
            nxt_st = mem_rdata_in;
            nxt_state = viu_pkg::S_IDLE;
         end
         default: nxt_state = viu_pkg::S_IDLE;
      endcase
      // Commit on the final memory cycle
      if (last_ack) begin
         nxt_load = 1'b1;
         if (kind_ff != viu_pkg::K_RET) begin
            nxt_inhibit = 1'b1;
         end
         if (kind_ff == viu_pkg::K_IRQ) begin
            nxt_st[`VIU_MASK_MSB:`VIU_MASK_LSB] = (lvl_ff == 4'h0) ? 4'h0 : lvl_ff - 4'h1;
         end
      end
      {nxt_maddr, nxt_mwdata} = mem_for(nxt_state, nxt_vaddr, nxt_new_wp, nxt_old_wp,
         nxt_old_pc, st_ff, nxt_ea);
   end

   // Sequencer registers; power-on request armed by reset
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_ff <= viu_pkg::S_IDLE;
         kind_ff <= viu_pkg::K_IRQ;
         st_ff <= `VIU_ST_RESET;
         old_wp_ff <= 16'h0000;
         old_pc_ff <= 16'h0000;
         new_wp_ff <= 16'h0000;
         new_pc_ff <= 16'h0000;
         vaddr_ff <= 16'h0000;
         ea_ff <= 16'h0000;
         lvl_ff <= 4'h0;
         inhibit_ff <= 1'b0;
         por_ff <= 1'b1;
         load_ff <= 1'b0;
         maddr_ff <= 16'h0000;
         mwdata_ff <= 16'h0000;
      end else if (ce_in) begin
         state_ff <= nxt_state;
         kind_ff <= nxt_kind;
         st_ff <= nxt_st;
         old_wp_ff <= nxt_old_wp;
         old_pc_ff <= nxt_old_pc;
         new_wp_ff <= nxt_new_wp;
         new_pc_ff <= nxt_new_pc;
         vaddr_ff <= nxt_vaddr;
         ea_ff <= nxt_ea;
         lvl_ff <= nxt_lvl;
         inhibit_ff <= nxt_inhibit;
         por_ff <= nxt_por;
         load_ff <= nxt_load;
         maddr_ff <= nxt_maddr;
         mwdata_ff <= nxt_mwdata;
      end
   end

   // Core and memory outputs
   assign busy_out = (state_ff != viu_pkg::S_IDLE);
   assign ctx_load_out = load_ff;
   assign ctx_wp_out = new_wp_ff;
   assign ctx_pc_out = new_pc_ff;
   assign status_word_out = st_ff;
   assign mem_req_out = (state_ff != viu_pkg::S_IDLE);
   assign mem_we_out = (state_ff == viu_pkg::S_SAVE_WP || state_ff == viu_pkg::S_SAVE_PC
      || state_ff == viu_pkg::S_SAVE_ST || state_ff == viu_pkg::S_SAVE_EA);
   assign mem_addr_out = maddr_ff;
   assign mem_wdata_out = mwdata_ff;

   // Error flags; set beats a same-cycle clear
   logic io_op;
   logic [15:0] err_set;
   logic [15:0] err_clr;
   assign io_op = set_io_bit_one_in | set_io_bit_zero_in;
   always_comb begin
      err_set = 16'h0000;
      err_clr = 16'h0000;
      if (LEVELS == 16) begin
         err_set[`VIU_EB_MAP] = err_map_in;
         err_set[`VIU_EB_BUSMEM] = err_busmem_in;
         err_set[`VIU_EB_ILLEGAL] = err_illegal_in;
         err_set[`VIU_EB_PRIV] = err_priv_in;
         err_set[`VIU_EB_TIMEOUT] = err_timeout_in;
      end
      if (io_op && io_base_in == `VIU_IO_ERR && io_bit_in >= 4'(`VIU_EB_MAP)) begin
         err_clr[io_bit_in] = 1'b1;
      end
      if (io_op && io_base_in == `VIU_IO_PROT && io_bit_in == 4'(`VIU_BIT_MAP)) begin
         err_clr[`VIU_EB_MAP] = 1'b1;
      end
      nxt_errreg = (errreg_ff & ~err_clr) | err_set;
      nxt_parity = (parity_ff & ~(io_op && io_base_in == `VIU_IO_PANEL
         && io_bit_in == 4'(`VIU_BIT_PARITY))) | err_parity_in;
      nxt_protect = (protect_ff & ~(set_io_bit_one_in && io_base_in == `VIU_IO_PROT))
         | (err_protect_in & PROT_FITTED);
   end

   // Error registers
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         errreg_ff <= 16'h0000;
         parity_ff <= 1'b0;
         protect_ff <= 1'b0;
      end else if (ce_in) begin
         errreg_ff <= nxt_errreg;
         parity_ff <= nxt_parity;
         protect_ff <= nxt_protect;
      end
   end

   // Avalon slave with one wait state
   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
   assign avs_readdata_out = rdata_ff;
   always_comb begin
      nxt_ack = (avs_read_in | avs_write_in) & ~ack_ff;
      nxt_rdata = rdata_ff;
      if (avs_read_in && !ack_ff) begin
         if (avs_address_in[4:2] == `VIU_REG_STATUS) begin
            nxt_rdata = {16'h0000, st_ff};
         end else if (avs_address_in[4:2] == `VIU_REG_WP) begin
            nxt_rdata = {16'h0000, new_wp_ff};
         end else if (avs_address_in[4:2] == `VIU_REG_PC) begin
            nxt_rdata = {16'h0000, new_pc_ff};
         end else if (avs_address_in[4:2] == `VIU_REG_PEND) begin
            nxt_rdata = {15'h0000, inhibit_ff, level_req};
         end else if (avs_address_in[4:2] == `VIU_REG_ERR) begin
            nxt_rdata = {16'h0000, errreg_ff[15:1], parity_ff};
         end else if (avs_address_in[4:2] == `VIU_REG_SENSE) begin
            nxt_rdata = {31'h00000000, protect_ff};
         end else begin
            nxt_rdata = 32'h00000000;
         end
      end
   end

   // Bus slave registers
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else if (ce_in) begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in || !ce_in);

   property p_prio;
      take_go |-> (level_req & ((16'h0001 << best_lvl) - 16'h0001)) == 16'h0000;
   endproperty
   a_prio: assert property (p_prio) else $error("higher level was pending");

   property p_mask_gate;
      (state_ff == viu_pkg::S_IDLE && best_valid && !por_ff
         && best_lvl > st_ff[15:12]) |-> !take_go;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("masked level taken");

   property p_vec_addr;
      take_go |=> mem_req_out && mem_addr_out == {10'h000, $past(best_lvl), 2'b00};
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");

   property p_save_wp;
      (state_ff == viu_pkg::S_SAVE_WP) |-> mem_we_out && mem_addr_out == new_wp_ff + 16'h001a;
   endproperty
   a_save_wp: assert property (p_save_wp) else $error("old wp saved wrong");

   property p_hold_off;
      (ctx_load_out && kind_ff != viu_pkg::K_RET) |-> inhibit_ff;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("switch before first instr");

   property p_new_mask;
      (last_ack && kind_ff == viu_pkg::K_IRQ && lvl_ff > 4'h1 && !st_we_in)
         |=> st_ff[15:12] == $past(lvl_ff) - 4'h1;
   endproperty
   a_new_mask: assert property (p_new_mask) else $error("mask not level minus one");

   property p_ret_st;
      (state_ff == viu_pkg::S_RET_ST && mem_ack_in && !st_we_in)
         |=> st_ff == $past(mem_rdata_in) && ctx_load_out;
   endproperty
   a_ret_st: assert property (p_ret_st) else $error("status not restored");

   property p_parity_clr;
      (io_op && io_base_in == 16'h1fe0 && io_bit_in == 4'hc && !err_parity_in)
         |=> !parity_ff;
   endproperty
   a_parity_clr: assert property (p_parity_clr) else $error("parity not cleared");

   c_irq: cover property (take_go ##[1:40] ctx_load_out);
   c_xop: cover property (state_ff == viu_pkg::S_SAVE_EA && mem_ack_in);
   c_ret: cover property (state_ff == viu_pkg::S_RET_ST && mem_ack_in);
endmodule : vectored_priority_interrupt_unit

// >>> testbench/mem_partner.sv
// Memory partner answering word accesses after a set delay
`timescale 1ns/1ps
module mem_partner (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Access from the unit
   input wire logic mem_req_in,
   input wire logic mem_we_in,
   input wire logic [15:0] mem_addr_in,
   input wire logic [15:0] mem_wdata_in,
   input wire logic [2:0] delay_in,
   // Answer
   output logic mem_ack_out,
   output logic [15:0] mem_rdata_out
);
   logic [15:0] words [0:1023];
   logic [2:0] wait_ff;
   logic [15:0] last_ff;
   // Outside ack the bus shows the inverse of the last word
   assign mem_rdata_out = mem_ack_out ? words[mem_addr_in[10:1]] : ~last_ff;
   // Wait states, then a one-cycle ack; a write lands at the ack edge
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem_ack_out <= 1'b0;
         wait_ff <= 3'h0;
         last_ff <= 16'h0000;
      end else if (mem_ack_out) begin
         mem_ack_out <= 1'b0;
         wait_ff <= 3'h0;
         last_ff <= mem_rdata_out;
         if (mem_we_in) words[mem_addr_in[10:1]] <= mem_wdata_in;
      end else if (mem_req_in) begin
         if (wait_ff >= delay_in) mem_ack_out <= 1'b1;
         else wait_ff <= wait_ff + 3'h1;
      end
   end
endmodule : mem_partner

// >>> testbench/tb.sv
// Self-checking bench of the vectored priority interrupt unit
`timescale 1ns/1ps
module tb;
   logic core_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [31:0] irq = 32'h0;
   logic [6:0] err = 7'h0;
   logic [5:0] stb = 6'h0;
   logic [15:0] cpu_wp = 16'h0, cpu_pc = 16'h0, st_wdata = 16'h0, xop_ea = 16'h0;
   logic [15:0] io_base = 16'h0, ctx_wp, ctx_pc, status, m_addr, m_wdata, m_rdata;
   logic [3:0] xop_num = 4'h0, io_bit = 4'h0;
   logic [4:0] av_a = 5'h0;
   logic av_r = 1'b0, av_w = 1'b0, busy, ctx_load, m_req, m_we, m_ack, av_wait;
   logic [31:0] av_d = 32'h0, av_q;
   logic [2:0] delay = 3'h0;
   int n_mismatch = 0, samples_checked = 0;
   // Unit under test
   vectored_priority_interrupt_unit #(.LEVELS(16), .SHARE(2), .PROT_FITTED(1'b1)) dut (
      .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .irq_lines_in(irq),
      .err_parity_in(err[0]), .err_protect_in(err[1]), .err_map_in(err[2]),
      .err_busmem_in(err[3]), .err_illegal_in(err[4]), .err_priv_in(err[5]),
      .err_timeout_in(err[6]), .instr_done_in(stb[0]), .cpu_wp_in(cpu_wp), .cpu_pc_in(cpu_pc),
      .st_we_in(stb[3]), .st_wdata_in(st_wdata), .return_restore_context_in(stb[1]),
      .extended_op_trap_in(stb[2]), .xop_num_in(xop_num), .xop_ea_in(xop_ea),
      .set_io_bit_one_in(stb[4]), .set_io_bit_zero_in(stb[5]), .io_base_in(io_base),
      .io_bit_in(io_bit), .busy_out(busy), .ctx_load_out(ctx_load), .ctx_wp_out(ctx_wp),
      .ctx_pc_out(ctx_pc), .status_word_out(status), .mem_req_out(m_req), .mem_we_out(m_we),
      .mem_addr_out(m_addr), .mem_wdata_out(m_wdata), .mem_rdata_in(m_rdata),
      .mem_ack_in(m_ack), .avs_address_in(av_a), .avs_read_in(av_r), .avs_write_in(av_w),
      .avs_writedata_in(av_d), .avs_readdata_out(av_q), .avs_waitrequest_out(av_wait));
   // Far-side memory
   mem_partner mem (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .mem_req_in(m_req),
      .mem_we_in(m_we), .mem_addr_in(m_addr), .mem_wdata_in(m_wdata), .delay_in(delay),
      .mem_ack_out(m_ack), .mem_rdata_out(m_rdata));
   // 50 MHz clock
   always #10 core_clk_in = ~core_clk_in;
   // Vector n, traps at 16 to 31, gets its own workspace
   function automatic logic [15:0] wp(input int n); return 16'h0080 + 16'(n * 32);
   endfunction : wp
   function automatic logic [15:0] pc(input int n); return 16'h4000 + 16'(n);
   endfunction : pc
   function automatic logic [15:0] word(input logic [15:0] a); return mem.words[a[10:1]];
   endfunction : word
   // Verdict for every ending
   task automatic close_out();
      $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One-cycle strobe
   task automatic pulse(input bit e, input int i);
      @(posedge core_clk_in);
      if (e) err[i] <= 1'b1;
      else stb[i] <= 1'b1;
      @(posedge core_clk_in);
      err <= 7'h0;
      stb <= 6'h0;
   endtask : pulse
   task automatic io(input int i, input logic [15:0] b, input int n);
      io_base <= b;
      io_bit <= 4'(n);
      pulse(1'b0, i);
   endtask : io
   // Bus cycle held until waitrequest is low
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge core_clk_in);
      av_a <= a;
      av_d <= d;
      av_r <= !wr;
      av_w <= wr;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk_in);
         if (av_wait === 1'b0) break;
      end
      q = av_q;
      av_r <= 1'b0;
      av_w <= 1'b0;
      if (n == 20) begin n_mismatch++; close_out(); end
   endtask : av
   task automatic wait_load();
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge core_clk_in);
         if (ctx_load === 1'b1) break;
      end
      if (n == 300) begin n_mismatch++; close_out(); end
   endtask : wait_load
   // Switch outcome; mask bit 4 set means the mask is not judged
   task automatic sw(input logic [15:0] nwp, npc, owp, opc, ost, input logic [4:0] msk);
      wait_load();
      chk("new wp", 32'(ctx_wp), 32'(nwp));
      chk("new pc", 32'(ctx_pc), 32'(npc));
      chk("saved wp", 32'(word(nwp + 16'd26)), 32'(owp));
      chk("saved pc", 32'(word(nwp + 16'd28)), 32'(opc));
      chk("saved st", 32'(word(nwp + 16'd30)), 32'(ost));
      if (!msk[4]) chk("mask", 32'(status[15:12]), 32'(msk[3:0]));
   endtask : sw
   task automatic no_take();
      logic b;
      b = 1'b0;
      repeat (8) begin
         @(posedge core_clk_in);
         if (busy !== 1'b0) b = 1'b1;
      end
      chk("no switch", 32'(b), 32'h0);
   endtask : no_take
   // Hang guard
   initial begin
      #2000000;
      n_mismatch++;
      close_out();
   end
   // Main sequence
   initial begin : main
      int b, m, h, k;
      logic [15:0] lv, owp, opc, ea, st, st_m;
      logic [31:0] q;
      void'($urandom(32'hc4e4));
      for (int n = 0; n < 32; n++) begin
         mem.words[2*n] = wp(n);
         mem.words[2*n+1] = pc(n);
      end
      repeat (2) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      sw(wp(0), pc(0), 16'h0, 16'h0, 16'h0, 5'h00);
      pulse(1'b0, 0);
      av(1'b1, 5'h00, 32'h0000f000, q);
      av(1'b0, 5'h00, 32'h0, q);
      chk("status", q, 32'h0000f000);
      // Random request sets; lowest level wins
      for (int i = 0; i < 8; i++) begin
         lv = (i == 0) ? 16'h8000 : (i == 1) ? 16'h0002 : 16'($urandom) & 16'hfffa;
         if (lv == 16'h0) lv = 16'h0010;
         b = 0;
         while (!lv[b]) b++;
         for (int j = 0; j < 16; j++) irq[2*j+int'($urandom % 2)] <= lv[j];
         owp = 16'($urandom) & 16'hfffe;
         opc = 16'($urandom) & 16'hfffe;
         cpu_wp <= owp;
         cpu_pc <= opc;
         st = {4'hf, 12'($urandom)};
         st_wdata <= st;
         delay <= 3'($urandom % 4);
         pulse(1'b0, 3);
         pulse(1'b0, 0);
         sw(wp(b), pc(b), owp, opc, st, 5'((b == 0) ? 0 : b - 1));
         irq <= 32'h0;
         pulse(1'b0, 0);
      end
      // Mask boundary, hold-off, nesting and return
      m = 1 + int'($urandom % 13);
      h = m - 1;
      st = {4'(m), 12'h0a5};
      st_m = {4'(h), 12'h0a5};
      st_wdata <= st;
      pulse(1'b0, 3);
      irq[2*m+2] <= 1'b1;
      pulse(1'b0, 0);
      no_take();
      irq[2*m+1] <= 1'b1;
      pulse(1'b0, 0);
      sw(wp(m), pc(m), owp, opc, st, 5'(h));
      irq[2*m+2] <= 1'b0;
      irq[2*h] <= 1'b1;
      cpu_wp <= wp(m);
      cpu_pc <= pc(m) + 16'h2;
      pulse(1'b0, 0);
      no_take();
      pulse(1'b0, 0);
      sw(wp(h), pc(h), wp(m), pc(m) + 16'h2, st_m, 5'((h == 0) ? 0 : h - 1));
      irq[2*h] <= 1'b0;
      cpu_wp <= wp(h);
      pulse(1'b0, 0);
      pulse(1'b0, 1);
      wait_load();
      chk("ret wp", 32'(ctx_wp), 32'(wp(m)));
      chk("ret pc", 32'(ctx_pc), 32'(pc(m) + 16'h2));
      chk("ret st", 32'(status), 32'(st_m));
      pulse(1'b0, 0);
      no_take();
      irq <= 32'h0;
      // Extended operation traps, last vector included
      for (int i = 0; i < 2; i++) begin
         k = (i == 0) ? 15 : int'($urandom % 15);
         ea = 16'($urandom);
         owp = 16'($urandom) & 16'hfffe;
         cpu_wp <= owp;
         cpu_pc <= opc;
         xop_num <= 4'(k);
         xop_ea <= ea;
         pulse(1'b0, 2);
         sw(wp(16 + k), pc(16 + k), owp, opc, st_m, 5'h10);
         chk("ea", 32'(word(wp(16 + k) + 16'd22)), 32'(ea));
      end
      av(1'b1, 5'h04, 32'hffffffff, q);
      av(1'b0, 5'h04, 32'h0, q);
      chk("wp reg", q, 32'(wp(16 + k)));
      av(1'b0, 5'h18, 32'h0, q);
      chk("unmapped", q, 32'h0);
      // Error sources and their clears
      pulse(1'b1, 0);
      av(1'b0, 5'h10, 32'h0, q);
      chk("parity", q, 32'h1);
      av(1'b0, 5'h0c, 32'h0, q);
      chk("level 2", 32'(q[2]), 32'h1);
      io(5, 16'h1fe0, 12);
      av(1'b0, 5'h10, 32'h0, q);
      chk("parity clr", q, 32'h0);
      pulse(1'b1, 1);
      av(1'b0, 5'h14, 32'h0, q);
      chk("sense", q, 32'h1);
      io(4, 16'h1fa0, int'($urandom % 16));
      av(1'b0, 5'h14, 32'h0, q);
      chk("sense clr", q, 32'h0);
      pulse(1'b1, 2);
      av(1'b0, 5'h10, 32'h0, q);
      chk("map", q, 32'h800);
      io(5, 16'h1fa0, 4);
      av(1'b0, 5'h10, 32'h0, q);
      chk("map clr", q, 32'h0);
      for (int j = 0; j < 4; j++) begin
         pulse(1'b1, 3 + j);
         av(1'b0, 5'h10, 32'h0, q);
         chk("cause", q, 32'h1 << (12 + j));
         io(4 + j % 2, 16'h1fc0, 12 + j);
         av(1'b0, 5'h10, 32'h0, q);
         chk("cause clr", q, 32'h0);
      end
      close_out();
   end
endmodule : tb
